// ===== common/pmrr_pkg.sv
// pmrr_pkg: constants and carrier types for the page-mode rom read controller
// assumes: one 250 MHz system clock; the rom pins are asynchronous to it
package pmrr_pkg;

  // ----------------------------------------------------------------
  // pin widths and arrangement
  // ----------------------------------------------------------------
  localparam int unsigned WORD_ADDR_W  = 21;  // word address pins
  localparam int unsigned LOW_DATA_W   = 30;  // data pins 0..29
  localparam int unsigned HALF_W       = 16;  // half-word width
  localparam int unsigned FULL_W       = 32;  // full word width
  localparam int unsigned REQ_ADDR_W   = 22;  // request address, half-word granular
  localparam int unsigned PAGE32_WORDS = 8;   // words per page, 32-bit
  localparam int unsigned PAGE16_WORDS = 16;  // words per page, 16-bit
  localparam int unsigned PAGE32_BITS  = 3;   // in-page bits, 32-bit
  localparam int unsigned PAGE16_BITS  = 4;   // in-page bits, 16-bit

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;    // sys_clk period
  localparam int unsigned T_ACC_NS      = 100;  // random access, max
  localparam int unsigned T_PAC_NS      = 30;   // page access, max
  localparam int unsigned T_OHZ_NS      = 20;   // output disable, max
  localparam int unsigned SYNC_CYC      = 2;    // synchroniser delay on data
  // waits round up; the two access waits add the synchroniser latency, the disable wait does not
  localparam int unsigned ACC_CYC =
    (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;
  localparam int unsigned PAC_CYC =
    (T_PAC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_CYC;
  localparam int unsigned OHZ_CYC =
    (T_OHZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 6;           // wait counter width
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // request from the user side
  typedef struct packed {
    logic                  wide;  // 1: 32-bit read, 0: 16-bit read
    logic [REQ_ADDR_W-1:0] addr;  // 32-bit: word in [20:0]; 16-bit: half-word
  } pmrr_req_t;

  // rom control pins, all registered
  typedef struct packed {
    logic                   chip_sel_n;  // chip select, active low
    logic                   out_en_n;    // output drive control, active low
    logic                   width_sel;   // 1: 32-bit, 0: 16-bit
    logic [WORD_ADDR_W-1:0] word_address_bus;
  } pmrr_pins_t;

  // controller states
  typedef enum logic [1:0] {
    PMRR_IDLE,
    PMRR_WAIT,
    PMRR_DISABLE
  } pmrr_state_t;

endpackage : pmrr_pkg

// ===== logic/pmrr_ctrl.sv
// pmrr_ctrl: bus-master controller reading the page-mode rom over its pins
// assumes: rom pins wired straight to this block; one request at a time
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - width select high 32-bit, low 16-bit
// - 16-bit: top pins drive lowest address bit
// - drive 21-bit word address on pins
// - 32-bit read: select low, drive low, width high
module pmrr_ctrl
  import pmrr_pkg::*;
(
  input  wire logic                  sys_clk,              // system clock
  input  wire logic                  reset,                // async, active high
  input  wire logic                  req_valid,            // read request
  output logic                       req_ready,            // request taken
  input  wire pmrr_req_t             req,                  // request carrier
  output logic                       rsp_valid,            // one-cycle data pulse
  output logic [FULL_W-1:0]          rsp_data,             // read data
  output logic                       rom_chip_sel_n,       // chip select pin
  output logic                       rom_out_en_n,         // output drive pin
  output logic                       rom_width_sel,        // width select pin
  output logic [WORD_ADDR_W-1:0]     word_address_bus,     // address pins
  input  wire logic [LOW_DATA_W-1:0] read_data_bus,        // data pins 0..29
  input  wire logic                  top_data_or_low_addr_a_i,  // pin 30 in
  output logic                       top_data_or_low_addr_a_o,  // pin 30 out
  output logic                       top_data_or_low_addr_a_oe, // pin 30 enable
  input  wire logic                  top_data_or_low_addr_b_i,  // pin 31 in
  output logic                       top_data_or_low_addr_b_o,  // pin 31 out
  output logic                       top_data_or_low_addr_b_oe  // pin 31 enable
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pmrr_state_t             state_r;      // controller state
  pmrr_pins_t              pins_r;       // registered control pins
  logic                    low_addr_r;   // half-word select
  logic                    top_oe_r;     // drive top pins as address
  logic [CNT_W-1:0]        cnt_r;        // wait counter
  logic                    page_ok_r;    // last access opened a page
  logic [FULL_W-1:0]       sync1_r;      // first sync stage
  logic [FULL_W-1:0]       sync2_r;      // second sync stage
  logic                    same_page;    // new request hits open page
  logic                    take;         // request accepted
  logic [WORD_ADDR_W-1:0]  req_word;     // word address of request
  logic                    req_low;      // half-word bit of request

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // word address split
  always_comb begin
    if (req.wide) begin
      req_word = req.addr[WORD_ADDR_W-1:0];
      req_low  = 1'b0;
    end else begin
      req_word = req.addr[REQ_ADDR_W-1:1];
      req_low  = req.addr[0];
    end
  end

  // page hit: only in-page bits may differ
  always_comb begin
    same_page = 1'b0;
    if (page_ok_r && (req.wide == pins_r.width_sel)) begin
      if (req.wide)
        same_page = req_word[WORD_ADDR_W-1:PAGE32_BITS]
                    == pins_r.word_address_bus[WORD_ADDR_W-1:PAGE32_BITS];
      else
        same_page = req_word[WORD_ADDR_W-1:PAGE16_BITS-1]
                    == pins_r.word_address_bus[WORD_ADDR_W-1:PAGE16_BITS-1];
    end
  end

  assign req_ready = (state_r == PMRR_IDLE);
  assign take      = req_valid && req_ready;

  // cut a wait count down to the counter width
  function automatic logic [CNT_W-1:0] CNT_WIDTH(input int unsigned v);
    CNT_WIDTH = v[CNT_W-1:0];
  endfunction : CNT_WIDTH

  // ----------------------------------------------------------------
  // controller state machine
  // ----------------------------------------------------------------
  // pins stay put until sampling ends
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= PMRR_IDLE;
      cnt_r   <= CNT_ZERO;
    end else begin
      case (state_r)
        PMRR_IDLE: begin
          if (take) begin
            state_r <= PMRR_WAIT;
            cnt_r   <= same_page ? CNT_WIDTH(PAC_CYC) : CNT_WIDTH(ACC_CYC);
          end
        end
        PMRR_WAIT: begin
          if (cnt_r == CNT_ONE) begin
            state_r <= PMRR_DISABLE;
            cnt_r   <= CNT_WIDTH(OHZ_CYC);
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        PMRR_DISABLE: begin
          // bus turnaround before top pins may be driven again
          if (cnt_r == CNT_ONE) begin
            state_r <= PMRR_IDLE;
            cnt_r   <= CNT_ZERO;
          end else begin
            cnt_r <= cnt_r - CNT_ONE;
          end
        end
        default: begin
          state_r <= PMRR_IDLE;
          cnt_r   <= CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // rom pins
  // ----------------------------------------------------------------
  // drive control pins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pins_r     <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, width_sel: 1'b1,
                      word_address_bus: '0};
      low_addr_r <= 1'b0;
      top_oe_r   <= 1'b0;
      page_ok_r  <= 1'b0;
    end else if (take) begin
      pins_r.chip_sel_n       <= 1'b0;
      pins_r.out_en_n         <= 1'b0;
      pins_r.width_sel        <= req.wide;
      pins_r.word_address_bus <= req_word;
      low_addr_r              <= req_low;
      // top pins become address only in 16-bit
      top_oe_r                <= !req.wide;
    end else if (state_r == PMRR_WAIT && cnt_r == CNT_ONE) begin
      // output drive off, chip stays selected so the page stays open
      pins_r.out_en_n <= 1'b1;
      page_ok_r       <= 1'b1;
    end
  end

  assign rom_chip_sel_n            = pins_r.chip_sel_n;
  assign rom_out_en_n              = pins_r.out_en_n;
  assign rom_width_sel             = pins_r.width_sel;
  assign word_address_bus          = pins_r.word_address_bus;
  assign top_data_or_low_addr_a_o  = low_addr_r;
  assign top_data_or_low_addr_b_o  = low_addr_r;
  // released in 32-bit so rom drives them
  assign top_data_or_low_addr_a_oe = top_oe_r;
  assign top_data_or_low_addr_b_oe = top_oe_r;

  // ----------------------------------------------------------------
  // data capture
  // ----------------------------------------------------------------
  // two-stage synchroniser on all data pins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {top_data_or_low_addr_b_i, top_data_or_low_addr_a_i, read_data_bus};
      sync2_r <= sync1_r;
    end
  end

  // sample at end of wait; 16-bit keeps low half
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else begin
      rsp_valid <= (state_r == PMRR_WAIT) && (cnt_r == CNT_ONE);
      if ((state_r == PMRR_WAIT) && (cnt_r == CNT_ONE))
        rsp_data <= pins_r.width_sel ? sync2_r
                                     : {{(FULL_W-HALF_W){1'b0}}, sync2_r[HALF_W-1:0]};
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_take;
    take;
  endsequence

  a_wide_read_pins: assert property (@(posedge sys_clk) disable iff (reset)
    s_take and req.wide |=> !rom_chip_sel_n && !rom_out_en_n && rom_width_sel)
    else $error("32-bit read pins wrong");
  a_narrow_width: assert property (@(posedge sys_clk) disable iff (reset)
    s_take |=> rom_width_sel == $past(req.wide))
    else $error("width select mismatch");
  a_low_addr_drive: assert property (@(posedge sys_clk) disable iff (reset)
    s_take and !req.wide |=> top_data_or_low_addr_a_oe && top_data_or_low_addr_b_oe
      && top_data_or_low_addr_a_o == $past(req.addr[0]))
    else $error("low address pins not driven");
  a_top_released: assert property (@(posedge sys_clk) disable iff (reset)
    rom_width_sel && !rom_chip_sel_n |-> !top_data_or_low_addr_a_oe
      && !top_data_or_low_addr_b_oe)
    else $error("top pins driven in 32-bit");
  a_addr_stable: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == PMRR_WAIT |=> $stable(word_address_bus) && $stable(top_data_or_low_addr_a_o))
    else $error("address moved during read");
  a_word_addr: assert property (@(posedge sys_clk) disable iff (reset)
    s_take and req.wide |=> word_address_bus == $past(req.addr[WORD_ADDR_W-1:0]))
    else $error("word address wrong");
  a_rsp_time: assert property (@(posedge sys_clk) disable iff (reset)
    s_take and !same_page |-> ##(ACC_CYC+1) rsp_valid)
    else $error("random read answer late or early");
  a_page_time: assert property (@(posedge sys_clk) disable iff (reset)
    s_take and same_page |-> ##(PAC_CYC+1) rsp_valid)
    else $error("page read answer late or early");
  a_narrow_data: assert property (@(posedge sys_clk) disable iff (reset)
    rsp_valid && !rom_width_sel |-> rsp_data[FULL_W-1:HALF_W] == '0)
    else $error("upper half not cleared in 16-bit");
  a_drive_off: assert property (@(posedge sys_clk) disable iff (reset)
    state_r == PMRR_DISABLE |-> rom_out_en_n)
    else $error("output drive left on");
  a_reset_standby: assert property (@(posedge sys_clk)
    reset |=> rom_chip_sel_n && rom_out_en_n && !top_data_or_low_addr_a_oe
      && !top_data_or_low_addr_b_oe)
    else $error("rom not in standby after reset");

endmodule : pmrr_ctrl

`default_nettype wire

// ===== bench/pmrr_rom_model.sv
// pmrr_rom_model: behavioural page-mode rom facing the read controller
// assumes: pins wired straight from pmrr_ctrl; the bench resolves the top pins
`timescale 1ns/1ns
`default_nettype none
module pmrr_rom_model
  import pmrr_pkg::*;
(
  input  wire logic                   chip_sel_n,
  input  wire logic                   out_en_n,
  input  wire logic                   width_sel,
  input  wire logic [WORD_ADDR_W-1:0] word_address_bus,
  input  wire logic [1:0]             top_o,
  input  wire logic [1:0]             top_oe,
  output logic      [FULL_W-1:0]      data_out,
  output logic                        viol
);
  // ------------------------------------------------------------------
  // settle tracking
  // ------------------------------------------------------------------
  realtime           t_chg     = 0;     // last pin change
  int                need      = 100;   // ns until data valid
  logic [17:0]       page_prev = '0;    // last page
  logic              wide_prev = 1'b1;  // last width
  logic              sel_prev  = 1'b1;  // last select
  logic [FULL_W-1:0] word;              // addressed content
  initial data_out = '0;
  initial viol = 1'b0;
  // same page and width gives page access
  always @(chip_sel_n, out_en_n, width_sel, word_address_bus, top_o) begin
    // a second wake in the same time step never shortens the wait
    if (!(!sel_prev && page_prev == word_address_bus[20:3] && wide_prev == width_sel))
      need = T_ACC_NS;
    else if ($realtime != t_chg)
      need = T_PAC_NS;
    page_prev = word_address_bus[20:3];
    wide_prev = width_sel;
    sel_prev = chip_sel_n;
    t_chg = $realtime;
  end
  // word or half-word by width level
  always #1 begin
    word = {word_address_bus[10:0], word_address_bus};
    // released or unsettled lines toggle
    // settles one ns inside its limit so the edge at the limit never races
    if (chip_sel_n || out_en_n || $realtime - t_chg < need - 1) begin
      data_out = ~data_out;
    end else if (width_sel) begin
      // full word, top pins as data
      data_out = word;
      viol = viol | (|top_oe);
    end else begin
      // upper lines float, top pins pick the half
      data_out[FULL_W-1:HALF_W] = ~data_out[FULL_W-1:HALF_W];
      data_out[HALF_W-1:0] = top_o[0] ? word[31:16] : word[15:0];
      viol = viol | !(&top_oe) | (top_o[0] != top_o[1]);
    end
  end
endmodule : pmrr_rom_model
`default_nettype wire

// ===== bench/tb.sv
// tb: self-checking bench for pmrr_ctrl against the rom model
// assumes: one 250 MHz clock; reset held 5 cycles
`timescale 1ns/1ns
`default_nettype none
module tb
  import pmrr_pkg::*;
;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0, req_ready, rsp_valid, viol;
  logic chip_sel_n, out_en_n, width_sel, a_i, a_o, a_oe, b_i, b_o, b_oe;
  logic [WORD_ADDR_W-1:0] wab;
  logic [FULL_W-1:0] rsp_data, rom_data, exp_q[$];
  pmrr_req_t req = '0;
  int n_errors = 0, checks_done = 0, cyc = 0, due_q[$];
  logic [31:0] seed = 32'h895C;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;
  // undriven top pins see the model's data lines 30 and 31
  assign a_i = a_oe ? a_o : rom_data[30];
  assign b_i = b_oe ? b_o : rom_data[31];
  pmrr_ctrl u_dut (.sys_clk(sys_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rom_chip_sel_n(chip_sel_n), .rom_out_en_n(out_en_n), .rom_width_sel(width_sel),
    .word_address_bus(wab), .read_data_bus(rom_data[29:0]),
    .top_data_or_low_addr_a_i(a_i), .top_data_or_low_addr_a_o(a_o),
    .top_data_or_low_addr_a_oe(a_oe), .top_data_or_low_addr_b_i(b_i),
    .top_data_or_low_addr_b_o(b_o), .top_data_or_low_addr_b_oe(b_oe));
  pmrr_rom_model u_rom (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .width_sel(width_sel), .word_address_bus(wab), .top_o({b_o, a_o}),
    .top_oe({b_oe, a_oe}), .data_out(rom_data), .viol(viol));
  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xorshift
  // content: word address repeated over 32 bits, 16-bit reads zero-extended
  function automatic logic [31:0] expect_word(input pmrr_req_t r);
    logic [31:0] w;
    w = r.wide ? {r.addr[10:0], r.addr[20:0]} : {r.addr[11:1], r.addr[21:1]};
    if (r.wide) return w;
    return r.addr[0] ? {16'h0000, w[31:16]} : {16'h0000, w[15:0]};
  endfunction : expect_word
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // one request: note the result, hold until taken, note its arrival cycle
  task automatic read_one(input pmrr_req_t r, input logic hit);
    int k = 0;
    exp_q.push_back(expect_word(r));
    req_valid <= 1'b1;
    req <= r;
    do begin
      @(negedge sys_clk);
      k++;
    end while (req_ready !== 1'b1 && k < 200);
    if (k >= 200) begin
      n_errors++;
      final_report();
    end
    @(posedge sys_clk);
    due_q.push_back(cyc + (hit ? PAC_CYC : ACC_CYC) + 1);
    req_valid <= 1'b0;
    @(posedge sys_clk);
  endtask : read_one
  // ------------------------------------------------------------------
  // monitor: each response against the oldest note
  // ------------------------------------------------------------------
  always @(negedge sys_clk) begin
    if (!reset && rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);  // no stray response
      else begin
        check(rsp_data, exp_q.pop_front());
        check(32'(cyc), 32'(due_q.pop_front()));
      end
    end
  end
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    pmrr_req_t r, r_prev;
    logic hit;
    int k;
    r_prev = '0;
    repeat (5) @(posedge sys_clk);
    check({31'h0, chip_sel_n}, 32'h1);
    check({30'h0, a_oe, b_oe}, 32'h0);
    reset <= 1'b0;
    for (int i = 0; i < 48; i++) begin
      seed = xorshift(seed);
      r.wide = (i < 2) ? i[0] : seed[31];
      r.addr = (i < 2) ? 22'h3FFFFF : seed[21:0];
      // half the time stay in the previous page, same width
      if (seed[30] && i > 1) begin
        r.wide = r_prev.wide;
        if (r.wide) r.addr[20:3] = r_prev.addr[20:3];
        else r.addr[21:4] = r_prev.addr[21:4];
      end
      hit = i > 0 && r.wide == r_prev.wide && (r.wide ? r.addr[20:3] == r_prev.addr[20:3]
            : r.addr[21:4] == r_prev.addr[21:4]);
      read_one(r, hit);
      r_prev = r;
    end
    for (k = 0; k < 200 && exp_q.size() > 0; k++) @(negedge sys_clk);
    check(32'(exp_q.size()), 32'h0);
    check({31'h0, out_en_n}, 32'h1);
    check({31'h0, viol}, 32'h0);
    final_report();
  end
endmodule : tb
`default_nettype wire
